// file: inc/fps_pkg.sv
// Package: shared constants and types for the flash program/erase sequencer
package fps_pkg;
	// ==========================================
	// Register offsets on the device interface
	localparam logic [1:0]  REG_CONTROL      = 2'h0;
	localparam logic [1:0]  REG_KEY          = 2'h1;
	localparam logic [1:0]  REG_TABLE_LOW    = 2'h2;
	localparam logic [1:0]  REG_TABLE_HIGH   = 2'h3;
	// ==========================================
	// Control register fields
	localparam int          BIT_START        = 15;
	localparam int          BIT_OP_WRITE_ENABLE         = 14;
	localparam int          BIT_SEQ_ERR      = 13;
	localparam int          BIT_ERASE        = 6;
	localparam logic [15:0] CONTROL_RESET    = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK    = 16'h604F;
	// ==========================================
	// Unlock key bytes
	localparam logic [7:0]  KEY_FIRST        = 8'h55;
	localparam logic [7:0]  KEY_SECOND       = 8'hAA;
	// ==========================================
	// Operation codes
	localparam logic [3:0]  OP_BULK          = 4'hF;
	localparam logic [3:0]  OP_GEN_SEG       = 4'hD;
	localparam logic [3:0]  OP_SEC_SEG       = 4'hC;
	localparam logic [3:0]  OP_WORD          = 4'h3;
	localparam logic [3:0]  OP_PAGE          = 4'h2;
	localparam logic [3:0]  OP_ROW           = 4'h1;
	localparam logic [3:0]  OP_CONFIG        = 4'h0;
	// ==========================================
	// Geometry
	localparam int          ROW_WORDS        = 64;
	localparam int          PAGE_WORDS       = 512;
	localparam int          ROW_BYTES        = 192;
	localparam int          PAGE_BYTES       = 1536;
	// ==========================================
	// Timing
	localparam int          ROW_OSC_CYCLES   = 11064;
	localparam real         OSC_MHZ          = 7.37;
	localparam real         CLK_MHZ          = 100.0;
	localparam int          ROW_TIME_CYCLES  = int'($ceil(real'(ROW_OSC_CYCLES) * CLK_MHZ / OSC_MHZ));
	// ==========================================
	// Kinds of flash action
	typedef enum logic [3:0] {
		FPS_ACT_NONE,
		FPS_ACT_BULK_ERASE,
		FPS_ACT_GEN_SEG_ERASE,
		FPS_ACT_SEC_SEG_ERASE,
		FPS_ACT_PAGE_ERASE,
		FPS_ACT_CFG_ERASE,
		FPS_ACT_WORD_PROG,
		FPS_ACT_ROW_PROG,
		FPS_ACT_CFG_PROG
	} fps_action_t;
endpackage : fps_pkg

// file: inc/fps_if.sv
// Interface: processor-side register port between core end and sequencer end
`timescale 1ns/10ps
interface fps_if;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [23:0] table_addr;
	logic        stall;
	modport device (input addr, input wdata, input wr, input rd, input table_addr,
		output rdata, output stall);
	modport core (output addr, output wdata, output wr, output rd, output table_addr,
		input rdata, input stall);
endinterface : fps_if

// file: verilog/fps_sequencer.sv
// Sequencer end: control and key registers, row buffer, self-timed flash operations
// Notes on behaviour
// - Row write lasts 11064 cycles of 7.37 MHz.
// - Setting start bit 15 begins the operation.
// - Hardware clears start bit at completion.
// - Software can set start, never clear it.
// - Core writes 0x55 then 0xAA consecutively first.
// - Key register write-only, low byte, reads zero.
// - Write-enable bit 14 gates all operations.
// - Bit 13 flags bad sequence or termination; here only a refused start sets it.
// - Erase bit 6 chooses erase or program.
// - Erase codes: bulk, segments, page, config byte.
// - Program codes: word, row, config byte.
// - Other operation codes are unimplemented, do nothing; here they still stall and run busy for the timed cycle with action NONE.
// - Control bits reset only on power-on.
// - Core stalls for the whole operation.
// - Core erases the page before rewriting rows.
// - Core loads 64 words before each row program.
// - Core presents page address before page erase.
// - Core issues two idle slots after start.
// - Sixty-four word buffer filled sequentially, aligned group.
// - Pages and rows aligned on 1536/192 bytes.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module fps_sequencer #(
	parameter int OP_CYCLES = fps_pkg::ROW_TIME_CYCLES
) (
	input  wire logic      i_mclk,        // System clock
	input  wire logic      i_reset_n,     // Power-on reset, active low
	fps_if.device          bus,           // Core-side register port
	output logic [23:0]    o_flash_addr,  // Target address, aligned for page erase and row program
	output logic [3:0]     o_flash_action,// Action under way
	output logic           o_flash_busy,  // Array operation running
	output logic [23:0]    o_flash_wdata, // Word for word or config program
	output logic [5:0]     o_row_index,   // Buffer read index during row program
	output logic [23:0]    o_row_word     // Buffer word at that index
);
	// Six bits at least, since the buffer index is read from the timer
	localparam int CW = ($clog2(OP_CYCLES + 1) > 6) ? $clog2(OP_CYCLES + 1) : 6;

	if (OP_CYCLES < 1) begin : g_bad_cycles
		$error("OP_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {FPS_ST_IDLE, FPS_ST_RUN, FPS_ST_DONE} fps_state_t;

	// ==========================================
	// Decode of operation field
	function automatic fps_pkg::fps_action_t decode_op(input logic erase, input logic [3:0] op);
		fps_pkg::fps_action_t a;
		a = fps_pkg::FPS_ACT_NONE;
		if (erase) begin
			case (op)
				fps_pkg::OP_BULK:    a = fps_pkg::FPS_ACT_BULK_ERASE;
				fps_pkg::OP_GEN_SEG: a = fps_pkg::FPS_ACT_GEN_SEG_ERASE;
				fps_pkg::OP_SEC_SEG: a = fps_pkg::FPS_ACT_SEC_SEG_ERASE;
				fps_pkg::OP_PAGE:    a = fps_pkg::FPS_ACT_PAGE_ERASE;
				fps_pkg::OP_CONFIG:  a = fps_pkg::FPS_ACT_CFG_ERASE;
				default:             a = fps_pkg::FPS_ACT_NONE;
			endcase
		end else begin
			case (op)
				fps_pkg::OP_WORD:    a = fps_pkg::FPS_ACT_WORD_PROG;
				fps_pkg::OP_ROW:     a = fps_pkg::FPS_ACT_ROW_PROG;
				fps_pkg::OP_CONFIG:  a = fps_pkg::FPS_ACT_CFG_PROG;
				default:             a = fps_pkg::FPS_ACT_NONE;
			endcase
		end
		return a;
	endfunction : decode_op

	// ==========================================
	// Registers
	logic                 start_reg;
	logic                 op_write_enable_reg;
	logic                 err_reg;
	logic                 erase_reg;
	logic [3:0]           op_reg;
	logic [1:0]           key_stage_reg;
	logic [23:0]          buf_mem [fps_pkg::ROW_WORDS];
	logic [15:0]          low_hold_reg;
	logic [23:0]          tbl_addr_reg;
	logic [23:0]          last_word_reg;
	fps_state_t           state_reg;
	logic [CW-1:0]        count_reg;
	logic [15:0]          rdata_reg;
	logic                 stall_reg;

	logic                 wr_ctl;
	logic                 wr_key;
	logic                 start_req;
	logic                 armed;
	fps_pkg::fps_action_t act;

	assign wr_ctl    = bus.wr && (bus.addr == fps_pkg::REG_CONTROL);
	assign wr_key    = bus.wr && (bus.addr == fps_pkg::REG_KEY);
	// Start only taken on a 0->1 write while idle
	assign start_req = wr_ctl && bus.wdata[fps_pkg::BIT_START] && !start_reg;
	// Enable and operation come from the start write itself, which also loads them
	assign armed     = (key_stage_reg == 2'h2) && bus.wdata[fps_pkg::BIT_OP_WRITE_ENABLE];
	assign act       = decode_op(bus.wdata[fps_pkg::BIT_ERASE], bus.wdata[3:0]);

	// ==========================================
	// Key sequence tracker: any other write breaks consecutiveness
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			key_stage_reg <= 2'h0;
		end else if (start_req) begin
			key_stage_reg <= 2'h0;
		end else if (wr_key && bus.wdata[7:0] == fps_pkg::KEY_FIRST) begin
			key_stage_reg <= 2'h1;
		end else if (wr_key && bus.wdata[7:0] == fps_pkg::KEY_SECOND && key_stage_reg == 2'h1) begin
			key_stage_reg <= 2'h2;
		end else if (bus.wr) begin
			key_stage_reg <= 2'h0;
		end
	end

	// ==========================================
	// Control register; i_reset_n is the power-on reset only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			op_write_enable_reg  <= fps_pkg::CONTROL_RESET[fps_pkg::BIT_OP_WRITE_ENABLE];
			erase_reg <= fps_pkg::CONTROL_RESET[fps_pkg::BIT_ERASE];
			op_reg    <= fps_pkg::CONTROL_RESET[3:0];
		end else if (wr_ctl && !start_reg) begin
			op_write_enable_reg  <= bus.wdata[fps_pkg::BIT_OP_WRITE_ENABLE];
			erase_reg <= bus.wdata[fps_pkg::BIT_ERASE];
			op_reg    <= bus.wdata[3:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			start_reg <= 1'b0;
		end else if (state_reg == FPS_ST_DONE) begin
			start_reg <= 1'b0;
		end else if (start_req && armed) begin
			start_reg <= 1'b1;
		end
	end

	// Error set on a refused start; set wins over a software clear
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			err_reg <= 1'b0;
		end else if (start_req && !armed) begin
			err_reg <= 1'b1;
		end else if (wr_ctl && !bus.wdata[fps_pkg::BIT_SEQ_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// ==========================================
	// Holding buffer, filled by table writes; low then high latch word
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_hold_reg  <= 16'h0000;
			tbl_addr_reg  <= 24'h000000;
			last_word_reg <= 24'h000000;
		end else if (bus.wr && bus.addr == fps_pkg::REG_TABLE_LOW) begin
			low_hold_reg <= bus.wdata;
			tbl_addr_reg <= bus.table_addr;
		end else if (bus.wr && bus.addr == fps_pkg::REG_TABLE_HIGH) begin
			last_word_reg <= {bus.wdata[7:0], low_hold_reg};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (bus.wr && bus.addr == fps_pkg::REG_TABLE_HIGH)
			buf_mem[bus.table_addr[6:1]] <= {bus.wdata[7:0], low_hold_reg};
	end

	// ==========================================
	// Operation timer
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= FPS_ST_IDLE;
			count_reg <= '0;
		end else begin
			case (state_reg)
				FPS_ST_IDLE: begin
					if (start_req && armed) begin
						state_reg <= FPS_ST_RUN;
						count_reg <= CW'(OP_CYCLES - 1);
					end
				end
				FPS_ST_RUN: begin
					if (count_reg == '0)
						state_reg <= FPS_ST_DONE;
					else
						count_reg <= count_reg - 1'b1;
				end
				default: state_reg <= FPS_ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Outputs and read data
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stall_reg      <= 1'b0;
			o_flash_busy   <= 1'b0;
			o_flash_action <= 4'h0;
			o_flash_addr   <= 24'h000000;
			o_flash_wdata  <= 24'h000000;
			o_row_index    <= 6'h00;
			o_row_word     <= 24'h000000;
		end else begin
			stall_reg    <= (state_reg == FPS_ST_IDLE && start_req && armed) ||
				(state_reg == FPS_ST_RUN && count_reg != '0);
			o_flash_busy <= (state_reg == FPS_ST_RUN);
			if (state_reg == FPS_ST_IDLE && start_req && armed) begin
				o_flash_action <= 4'(act);
				o_flash_wdata  <= last_word_reg;
				// Page erase aligned to 512-word page, row to 64-word row
				if (act == fps_pkg::FPS_ACT_PAGE_ERASE)
					o_flash_addr <= {tbl_addr_reg[23:10], 10'h000};
				else if (act == fps_pkg::FPS_ACT_ROW_PROG)
					o_flash_addr <= {tbl_addr_reg[23:7], 7'h00};
				else
					o_flash_addr <= tbl_addr_reg;
			end
			o_row_index <= count_reg[5:0];
			o_row_word  <= buf_mem[count_reg[5:0]];
		end
	end

	// Key register always reads zero
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= 16'h0000;
		end else if (bus.rd && bus.addr == fps_pkg::REG_CONTROL) begin
			rdata_reg <= {start_reg, op_write_enable_reg, err_reg, 6'h00, erase_reg, 2'h0, op_reg};
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	assign bus.rdata = rdata_reg;
	assign bus.stall = stall_reg;
endmodule : fps_sequencer

// file: verilog/fps_core_port.sv
// Core end: turns user commands into register and table writes, honours stall
`timescale 1ns/10ps
module fps_core_port (
	input  wire logic        i_mclk,      // System clock
	input  wire logic        i_reset_n,   // Reset, active low
	fps_if.core              bus,         // Register port to sequencer
	input  wire logic        i_wr,        // User write strobe
	input  wire logic        i_rd,        // User read strobe
	input  wire logic [1:0]  i_addr,      // User register offset
	input  wire logic [15:0] i_wdata,     // User write data
	input  wire logic [23:0] i_table_addr,// Table pointer for table writes
	output logic [15:0]      o_rdata,     // Read data, three clock edges after read strobe
	output logic             o_stalled,   // Core held by flash operation
	output logic             o_ready      // Strobes of the previous cycle accepted
);
	// ==========================================
	// While stalled, strobes are dropped; the core is frozen in real silicon
	logic        wr_reg;
	logic        rd_reg;
	logic [1:0]  addr_reg;
	logic [15:0] wdata_reg;
	logic [23:0] tbl_reg;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			addr_reg  <= 2'h0;
			wdata_reg <= 16'h0000;
			tbl_reg   <= 24'h000000;
		end else begin
			wr_reg    <= i_wr && !bus.stall;
			rd_reg    <= i_rd && !bus.stall;
			addr_reg  <= i_addr;
			wdata_reg <= i_wdata;
			tbl_reg   <= i_table_addr;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata   <= 16'h0000;
			o_stalled <= 1'b0;
			o_ready   <= 1'b0;
		end else begin
			o_rdata   <= bus.rdata;
			o_stalled <= bus.stall;
			o_ready   <= !bus.stall;
		end
	end

	// Key order, buffer loading and page erase order are the user's duty
	assign bus.wr         = wr_reg;
	assign bus.rd         = rd_reg;
	assign bus.addr       = addr_reg;
	assign bus.wdata      = wdata_reg;
	assign bus.table_addr = tbl_reg;
endmodule : fps_core_port

// file: tb/fps_seq_chk.sv
// Checker: register-port timing and status relations of the sequencer
`timescale 1ns/10ps
module fps_seq_chk #(
	parameter int OP_CYCLES = 20
) (
	input  wire logic        i_mclk,    // System clock
	input  wire logic        i_reset_n, // Reset, active low
	input  wire logic [1:0]  addr,      // Register offset
	input  wire logic [15:0] wdata,     // Write data
	input  wire logic        wr,        // Write strobe
	input  wire logic        rd,        // Read strobe
	input  wire logic [15:0] rdata,     // Read data
	input  wire logic        stall      // Core stall
);
	// ==========================================
	// Shadow of key, fields and timing
	logic       armed_reg;
	logic       last55_reg;
	logic       err_reg;
	logic       op_write_enable_reg;
	logic       erase_reg;
	logic [3:0] op_reg;
	logic [2:0] pend_reg;
	logic [1:0] idle_reg;
	int         run_reg;
	wire        ctl_wr = wr && addr == fps_pkg::REG_CONTROL && !stall;
	wire        try_st = ctl_wr && wdata[15] && pend_reg == 3'h0;
	wire        good   = try_st && armed_reg && wdata[14];
	wire        bad    = try_st && !good;
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{armed_reg, last55_reg} <= 2'h0;
		end else if (wr) begin
			last55_reg <= addr == fps_pkg::REG_KEY && wdata[7:0] == fps_pkg::KEY_FIRST;
			armed_reg  <= last55_reg && addr == fps_pkg::REG_KEY && wdata[7:0] == fps_pkg::KEY_SECOND;
		end
	end
	// Fields frozen while an operation is pending or running
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{op_write_enable_reg, erase_reg, op_reg, err_reg} <= 7'h00;
		end else if (ctl_wr && pend_reg == 3'h0) begin
			{op_write_enable_reg, erase_reg, op_reg} <= {wdata[14], wdata[6], wdata[3:0]};
			err_reg <= bad || (err_reg && wdata[13]);
		end
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_reg <= 3'h0;
			idle_reg <= 2'h0;
			run_reg  <= 0;
		end else begin
			pend_reg <= {pend_reg[1:0], good};
			idle_reg <= (stall || good || pend_reg != 3'h0) ? 2'h0 : (idle_reg == 2'h3 ? idle_reg : idle_reg + 2'h1);
			run_reg  <= stall ? run_reg + 1 : 0;
		end
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	keyed_start_stall_a: assert property (good |-> ##[1:3] stall)
		else $error("no stall after keyed start");
	bad_start_quiet_a: assert property (bad |=> !stall [*3])
		else $error("stall after refused start");
	stall_length_a: assert property ($fell(stall) |-> run_reg == OP_CYCLES)
		else $error("operation length wrong");
	stall_cause_a: assert property ($rose(stall) |-> pend_reg != 3'h0)
		else $error("stall without keyed start");
	other_read_zero_a: assert property (rd && addr != fps_pkg::REG_CONTROL |=> rdata == 16'h0000)
		else $error("key or table offset read not zero");
	start_cleared_a: assert property (rd && addr == fps_pkg::REG_CONTROL && idle_reg == 2'h3 |=> !rdata[15])
		else $error("start bit still set while idle");
	fields_read_a: assert property (rd && addr == fps_pkg::REG_CONTROL && idle_reg == 2'h3 |=>
		rdata[14] == op_write_enable_reg && rdata[12:0] == {6'h00, erase_reg, 2'h0, op_reg})
		else $error("control fields read back wrong");
	err_flag_a: assert property (rd && addr == fps_pkg::REG_CONTROL && idle_reg == 2'h3 |=> rdata[13] == err_reg)
		else $error("sequence error flag wrong");
	keyed_c: cover property (good ##[1:3] stall);
	refused_c: cover property (bad);
	done_c: cover property ($fell(stall));
endmodule : fps_seq_chk

// file: tb/flash_program_erase_sequencer_tb.sv
// Testbench: core end and sequencer end joined, driven from the user side
`timescale 1ns/10ps
module flash_program_erase_sequencer_tb;
	localparam int OPC = 20;
	typedef struct packed {logic er; logic [3:0] op; fps_pkg::fps_action_t act;} fps_row_t;
	logic        i_mclk;
	logic        i_reset_n;
	logic        u_wr;
	logic        u_rd;
	logic [1:0]  u_addr;
	logic [15:0] u_wdata;
	logic [23:0] u_tbl;
	logic [23:0] o_flash_addr;
	logic [23:0] o_flash_wdata;
	logic [5:0]  o_row_index;
	logic [23:0] o_row_word;
	logic [15:0] o_rdata;
	logic        o_stalled;
	logic        o_ready;
	logic        o_flash_busy;
	logic [3:0]  o_flash_action;
	logic [15:0] d;
	logic [3:0]  act;
	logic        stl;
	int          len;
	int          n_errors;
	int          checks;
	fps_row_t    rows [14] = '{
		'{1'b1, 4'hF, fps_pkg::FPS_ACT_BULK_ERASE}, '{1'b1, 4'hD, fps_pkg::FPS_ACT_GEN_SEG_ERASE},
		'{1'b1, 4'hC, fps_pkg::FPS_ACT_SEC_SEG_ERASE}, '{1'b1, 4'h2, fps_pkg::FPS_ACT_PAGE_ERASE},
		'{1'b1, 4'h0, fps_pkg::FPS_ACT_CFG_ERASE}, '{1'b1, 4'h3, fps_pkg::FPS_ACT_NONE},
		'{1'b1, 4'h1, fps_pkg::FPS_ACT_NONE}, '{1'b0, 4'h3, fps_pkg::FPS_ACT_WORD_PROG},
		'{1'b0, 4'h1, fps_pkg::FPS_ACT_ROW_PROG}, '{1'b0, 4'h0, fps_pkg::FPS_ACT_CFG_PROG},
		'{1'b0, 4'hF, fps_pkg::FPS_ACT_NONE}, '{1'b0, 4'hD, fps_pkg::FPS_ACT_NONE},
		'{1'b0, 4'hC, fps_pkg::FPS_ACT_NONE}, '{1'b0, 4'h2, fps_pkg::FPS_ACT_NONE}};
	fps_if bus ();
	fps_sequencer #(.OP_CYCLES(OPC)) i_fps_sequencer (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(bus),
		.o_flash_addr(o_flash_addr), .o_flash_action(o_flash_action), .o_flash_busy(o_flash_busy),
		.o_flash_wdata(o_flash_wdata), .o_row_index(o_row_index), .o_row_word(o_row_word));
	fps_core_port i_fps_core_port (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(bus), .i_wr(u_wr),
		.i_rd(u_rd), .i_addr(u_addr), .i_wdata(u_wdata), .i_table_addr(u_tbl), .o_rdata(o_rdata),
		.o_stalled(o_stalled), .o_ready(o_ready));
	fps_seq_chk #(.OP_CYCLES(OPC)) i_fps_seq_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .addr(bus.addr),
		.wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .stall(bus.stall));
	always #5 i_mclk = ~i_mclk;
	// ==========================================
	// Bus and check tasks
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic chk24(input string s, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk24
	// Strobes sent while stalled would be dropped silently
	task automatic wait_ready();
		int n;
		n = 0;
		do @(posedge i_mclk); while (o_ready !== 1'b1 && ++n < 200);
		if (n >= 200) begin
			n_errors++;
			results();
		end
	endtask : wait_ready
	task automatic put(input logic [1:0] a, input logic [15:0] v);
		wait_ready();
		u_addr  <= a;
		u_wdata <= v;
		u_wr    <= 1'b1;
		@(posedge i_mclk);
		u_wr    <= 1'b0;
	endtask : put
	task automatic get(input logic [1:0] a, output logic [15:0] v);
		wait_ready();
		u_addr <= a;
		u_rd   <= 1'b1;
		@(posedge i_mclk);
		u_rd   <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 v = o_rdata;
	endtask : get
	task automatic fire(input logic [15:0] c);
		put(fps_pkg::REG_KEY, {8'h00, fps_pkg::KEY_FIRST});
		put(fps_pkg::REG_KEY, {8'h00, fps_pkg::KEY_SECOND});
		put(fps_pkg::REG_CONTROL, c);
	endtask : fire
	task automatic run(output int n_busy, output logic [3:0] a, output logic s);
		int n;
		n_busy = 0;
		a = 4'h0;
		s = 1'b0;
		for (n = 0; n < 10 && o_flash_busy !== 1'b1; n++) @(negedge i_mclk);
		while (o_flash_busy === 1'b1 && n_busy < 1000) begin
			if (n_busy == OPC / 2) begin
				a = o_flash_action;
				s = o_stalled;
			end
			n_busy++;
			@(negedge i_mclk);
		end
		if (n_busy >= 1000) begin
			n_errors++;
			results();
		end
		@(posedge i_mclk);
	endtask : run
	// ==========================================
	// Main sequence
	initial begin
		{i_mclk, i_reset_n, u_wr, u_rd, u_addr, u_wdata, u_tbl} = 46'h0;
		{n_errors, checks} = '0;
		repeat (4) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		get(fps_pkg::REG_CONTROL, d);
		chk("control after reset", 16'h0000, d);
		for (int a = 1; a < 4; a++) begin
			get(2'(a), d);
			chk("write-only offset", 16'h0000, d);
		end
		$display("reset test done");
		foreach (rows[i]) begin
			fire({2'b11, 7'h00, rows[i].er, 2'h0, rows[i].op});
			run(len, act, stl);
			chk("busy length", 16'(OPC), 16'(len));
			chk("action", {12'h000, rows[i].act}, {12'h000, act});
			chk("stall", 16'h0001, {15'h0000, stl});
			get(fps_pkg::REG_CONTROL, d);
			chk("control after op", {3'b010, 6'h00, rows[i].er, 2'h0, rows[i].op}, d);
			$display("case %0d done", i);
		end
		// No key, broken key, write disabled, reused key
		for (int k = 0; k < 4; k++) begin
			case (k)
				0: put(fps_pkg::REG_CONTROL, 16'hC001);
				1: begin
					put(fps_pkg::REG_KEY, {8'h00, fps_pkg::KEY_FIRST});
					put(fps_pkg::REG_CONTROL, 16'h4001);
					fire(16'hC001);
					run(len, act, stl);
					put(fps_pkg::REG_KEY, {8'h00, fps_pkg::KEY_FIRST});
					put(fps_pkg::REG_CONTROL, 16'h4001);
					put(fps_pkg::REG_KEY, {8'h00, fps_pkg::KEY_SECOND});
					put(fps_pkg::REG_CONTROL, 16'hC001);
				end
				2: fire(16'h8001);
				default: begin
					fire(16'hC001);
					run(len, act, stl);
					put(fps_pkg::REG_CONTROL, 16'hC001);
				end
			endcase
			run(len, act, stl);
			chk("refused start busy", 16'h0000, 16'(len));
			get(fps_pkg::REG_CONTROL, d);
			chk("refused start control", k == 2 ? 16'h2001 : 16'h6001, d);
			put(fps_pkg::REG_CONTROL, 16'h4001);
			get(fps_pkg::REG_CONTROL, d);
			chk("error cleared", 16'h4001, d);
			$display("refusal %0d done", k);
		end
		// ==========================================
		// Row buffer load, page erase, row program, word program
		for (int w = 0; w < fps_pkg::ROW_WORDS; w++) begin
			u_tbl <= 24'h012380 + 24'(2 * w);
			put(fps_pkg::REG_TABLE_LOW, {8'hBE, 2'b00, 6'(w)});
			put(fps_pkg::REG_TABLE_HIGH, {10'h000, 6'(w)});
		end
		chk24("row buffer word 0", 24'h00BE00, o_row_word);
		fire(16'hC042);
		run(len, act, stl);
		chk24("page erase address", 24'h012000, o_flash_addr);
		fire(16'hC001);
		for (int n = 0; n < 40 && o_row_index !== 6'h05; n++) @(negedge i_mclk);
		chk24("row buffer word 5", 24'h05BE05, o_row_word);
		run(len, act, stl);
		chk24("row program address", 24'h012380, o_flash_addr);
		fire(16'hC003);
		run(len, act, stl);
		chk24("word program data", 24'h3FBE3F, o_flash_wdata);
		chk24("word program address", 24'h0123FE, o_flash_addr);
		$display("table test done");
		results();
	end
endmodule : flash_program_erase_sequencer_tb
